// >>> design/tbc_codec.v
// Tape block codec: Manchester write path with check generator, 2/3-cell read decoder, APB registers.
// Assumes pclk at 50 MHz; tape read data and tachometer arrive asynchronously.
//
// Functional notes
// - Block: preamble, data, check, postamble, gaps around
// - Write gate energizes head; read-back runs concurrently
// - Gap written with gate on, encoder off
// - Appending waits for previous gap before gating
// - Back up three inches, then run forward
// - Encoder/check controls latch at byte boundaries
// - Dummy bytes, then preamble with encoder enabled
// - Accumulate starts with first data bit
// - Emit shifts out 16-bit check after byte
// - Clearing controls resets generator, restores bytes
// - Encoder stops after last postamble bit
// - Counted gap bytes then completion flag
// - Stop tape after block; count retries on error
// - Read only while forward at slow speed
// - Fields are whole bytes, Manchester serial
// - One rising, zero falling, extra boundary transitions
// - Preamble fifteen zeros then one; sync falls
// - Ignore transitions until 2/3 bit time
// - Eight significant bits form byte, ready flag
// - Byte while ready high: overrun, error, lost
// - Checking spans data through check, software gated
// - Mismatch flag high for corrupted block
// - Data field carries 1024 bytes
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tbc_regs.vh"
module tbc_codec (
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Tape head
  output reg         write_gate,
  output reg         write_data,
  input  wire        read_data,
  // Tape motion
  input  wire        tach_pulse,
  output reg         run_tape,
  output reg         tape_fast,
  output reg         tape_fwd
);
  // ----------------------------------------
  // Local state codes
  // ----------------------------------------
  localparam RX_HUNT = 2'd0;
  localparam RX_PRE  = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam MV_IDLE = 2'd0;
  localparam MV_BACK = 2'd1;
  localparam [31:0] HALF_LAST = `TBC_HALF_CYC - 1;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [9:0]  ctrl_r;
  reg  [15:0] gap_len_r;
  reg  [3:0]  rmax_r;
  reg  [3:0]  rcnt_r;
  reg         err_r;
  reg         done_r;
  reg         gap_seen_r;
  reg  [7:0]  tx_hold_r;
  reg         tx_full_r;
  reg  [7:0]  tx_sh_r;
  reg  [9:0]  half_cnt_r;
  reg         phase_r;
  reg  [2:0]  bitn_r;
  reg         wg_d_r;
  reg         start_pend_r;
  reg         enc_on_r;
  reg         acc_on_r;
  reg         emit_on_r;
  reg         blk_r;
  reg  [15:0] gap_cnt_r;
  reg  [1:0]  rx_st_r;
  reg  [12:0] el_r;
  reg  [12:0] est_r;
  reg  [3:0]  zcnt_r;
  reg  [2:0]  rbit_r;
  reg  [7:0]  rx_sh_r;
  reg  [7:0]  rx_hold_r;
  reg         rx_rdy_r;
  reg         rd_prev_r;
  reg         tach_prev_r;
  reg  [1:0]  mv_st_r;
  reg  [9:0]  mv_cnt_r;
  reg  [31:0] rd_val;
  wire [1:0]  sync_w;
  wire        rd_s;
  wire        tach_s;
  wire [15:0] tx_crc;
  wire [15:0] rx_crc;
  wire        apb_wr;
  wire        apb_rd;
  wire        wr_ctrl;
  wire        wr_stat;
  wire        wr_txd;
  wire        rd_rxd;
  wire        tick;
  wire        boundary;
  wire        mid;
  wire        cur_bit;
  wire        rx_en;
  wire        rise;
  wire        fall;
  wire [13:0] thr;
  wire        win;
  wire        rx_take;
  wire        byte_done;
  wire        tach_edge;
  wire        ovr;
  wire        urun;
  wire        blk_end;
  wire        retry_evt;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  tbc_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .din     ({tach_pulse, read_data}),
    .dout    (sync_w)
  );
  assign rd_s   = sync_w[0];
  assign tach_s = sync_w[1];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign apb_wr  = psel & penable & pready & pwrite;
  assign apb_rd  = psel & penable & pready & ~pwrite;
  assign wr_ctrl = apb_wr & (paddr == `TBC_OFF_CTRL);
  assign wr_stat = apb_wr & (paddr == `TBC_OFF_STAT);
  assign wr_txd  = apb_wr & (paddr == `TBC_OFF_TXD);
  assign rd_rxd  = apb_rd & (paddr == `TBC_OFF_RXD);

  always @* begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `TBC_OFF_CTRL:  rd_val = {22'h00_0000, 1'b0, ctrl_r[8:0]};
      `TBC_OFF_STAT:  rd_val = {24'h00_0000, gap_seen_r, (rcnt_r == rmax_r), done_r,
                                rx_st_r == RX_DATA, |rx_crc, err_r, rx_rdy_r, ~tx_full_r};
      `TBC_OFF_RXD:   rd_val = {24'h00_0000, rx_hold_r};
      `TBC_OFF_GAP:   rd_val = {16'h0000, gap_len_r};
      `TBC_OFF_RETRY: rd_val = {20'h0_0000, rcnt_r, 4'h0, rmax_r};
      default:        rd_val = 32'h0000_0000;
    endcase
  end

  // Zero-wait answer: pready raised in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `TBC_OFF_RETRY | paddr[1:0] != 2'b00);
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= 10'h000;
      gap_len_r <= `TBC_RST_GAP;
      rmax_r    <= `TBC_RST_RMAX;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[9:0];
      end else begin
        ctrl_r[`TBC_C_BACKUP] <= 1'b0;
        if (blk_end) begin
          ctrl_r[`TBC_C_RUN] <= 1'b0;
        end
      end
      if (apb_wr && paddr == `TBC_OFF_GAP) begin
        gap_len_r <= pwdata[15:0];
      end
      if (apb_wr && paddr == `TBC_OFF_RETRY) begin
        rmax_r <= pwdata[3:0];
      end
    end
  end

  // Sticky flags: hardware set wins over software clear for err_r, done_r; APPEND low clears gap_seen_r; RETRY write clears rcnt_r
  assign retry_evt = blk_end & (err_r | (|rx_crc));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r      <= 1'b0;
      done_r     <= 1'b0;
      gap_seen_r <= 1'b0;
      rcnt_r     <= 4'h0;
    end else if (clk_en) begin
      if (ovr | urun) begin
        err_r <= 1'b1;
      end else if (wr_stat & pwdata[`TBC_S_ERR]) begin
        err_r <= 1'b0;
      end
      if (blk_end) begin
        done_r <= 1'b1;
      end else if (wr_stat & pwdata[`TBC_S_DONE]) begin
        done_r <= 1'b0;
      end
      if (!ctrl_r[`TBC_C_APPEND]) begin
        gap_seen_r <= 1'b0;
      end else if (rx_st_r == RX_DATA && el_r > {est_r[11:0], 1'b0}) begin
        gap_seen_r <= 1'b1;
      end
      if (apb_wr && paddr == `TBC_OFF_RETRY) begin
        rcnt_r <= 4'h0;
      end else if (retry_evt && rcnt_r != rmax_r) begin
        rcnt_r <= rcnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Tape motion
  // ----------------------------------------
  assign tach_edge = tach_s & ~tach_prev_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mv_st_r     <= MV_IDLE;
      mv_cnt_r    <= 10'h000;
      tach_prev_r <= 1'b0;
      run_tape    <= 1'b0;
      tape_fast   <= 1'b0;
      tape_fwd    <= 1'b0;
    end else if (clk_en) begin
      tach_prev_r <= tach_s;
      case (mv_st_r)
        MV_IDLE: begin
          run_tape  <= ctrl_r[`TBC_C_RUN];
          tape_fast <= ctrl_r[`TBC_C_FAST];
          tape_fwd  <= ctrl_r[`TBC_C_FWD];
          if (ctrl_r[`TBC_C_BACKUP]) begin
            mv_st_r   <= MV_BACK;
            mv_cnt_r  <= 10'h000;
            run_tape  <= 1'b1;
            tape_fast <= 1'b0;
            tape_fwd  <= 1'b0;
          end
        end
        MV_BACK: begin
          if (tach_edge) begin
            mv_cnt_r <= mv_cnt_r + 10'h001;
          end
          if (mv_cnt_r == `TBC_BACKUP_PLS) begin
            mv_st_r  <= MV_IDLE;
            tape_fwd <= 1'b1;
          end
        end
        default: mv_st_r <= MV_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  assign tick     = write_gate & (half_cnt_r == HALF_LAST[9:0]);
  assign boundary = tick & phase_r & (bitn_r == 3'd7);
  assign mid      = tick & ~phase_r;
  assign cur_bit  = emit_on_r ? tx_crc[15] : tx_sh_r[7];
  assign urun     = boundary & ~tx_full_r;
  assign blk_end  = boundary & blk_r & ~enc_on_r & (gap_cnt_r == gap_len_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_gate   <= 1'b0;
      wg_d_r       <= 1'b0;
      tx_hold_r    <= 8'h00;
      tx_full_r    <= 1'b0;
      tx_sh_r      <= 8'h00;
      half_cnt_r   <= 10'h000;
      phase_r      <= 1'b0;
      bitn_r       <= 3'd0;
      start_pend_r <= 1'b0;
      enc_on_r     <= 1'b0;
      acc_on_r     <= 1'b0;
      emit_on_r    <= 1'b0;
      write_data   <= 1'b0;
      blk_r        <= 1'b0;
      gap_cnt_r    <= 16'h0000;
    end else if (clk_en) begin
      write_gate <= ctrl_r[`TBC_C_WG] & (~ctrl_r[`TBC_C_APPEND] | gap_seen_r);
      wg_d_r     <= write_gate;
      if (wr_txd) begin
        tx_hold_r <= pwdata[7:0];
        tx_full_r <= 1'b1;
      end else if (boundary) begin
        tx_full_r <= 1'b0;
      end
      start_pend_r <= 1'b0;
      if (write_gate & ~wg_d_r) begin
        half_cnt_r <= HALF_LAST[9:0];
        phase_r    <= 1'b1;
        bitn_r     <= 3'd7;
      end else if (tick) begin
        half_cnt_r <= 10'h000;
        phase_r    <= ~phase_r;
        if (phase_r) begin
          start_pend_r <= 1'b1;
          bitn_r       <= bitn_r + 3'd1;
          if (bitn_r == 3'd7) begin
            tx_sh_r   <= tx_full_r ? tx_hold_r : 8'h00;
            enc_on_r  <= ctrl_r[`TBC_C_ENC];
            acc_on_r  <= ctrl_r[`TBC_C_ACC];
            emit_on_r <= ctrl_r[`TBC_C_EMIT];
          end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          end
        end else if (enc_on_r) begin
          write_data <= cur_bit;
        end
      end else if (write_gate) begin
        half_cnt_r <= half_cnt_r + 10'h001;
      end
      if (start_pend_r && enc_on_r) begin
        write_data <= ~cur_bit;
      end
      if (boundary && enc_on_r) begin
        blk_r     <= 1'b1;
        gap_cnt_r <= 16'h0000;
      end else if (blk_end) begin
        blk_r <= 1'b0;
      end else if (boundary && blk_r) begin
        gap_cnt_r <= gap_cnt_r + 16'h0001;
      end
    end
  end

  tbc_crc u_tx_crc (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .clr      (~acc_on_r),
    .shift_en (mid & enc_on_r & acc_on_r),
    .emit     (emit_on_r),
    .din      (tx_sh_r[7]),
    .crc      (tx_crc)
  );

  // ----------------------------------------
  // Read decoder (2/3-cell timer)
  // ----------------------------------------
  assign rx_en     = run_tape & tape_fwd & ~tape_fast;
  assign rise      = rd_s & ~rd_prev_r;
  assign fall      = ~rd_s & rd_prev_r;
  assign thr       = ({1'b0, est_r} * 14'd2) / 14'd3;
  assign win       = {1'b0, el_r} >= thr;
  assign rx_take   = (rx_st_r == RX_DATA) & (rise | fall) & win;
  assign byte_done = rx_take & (rbit_r == 3'd7);
  assign ovr       = byte_done & rx_rdy_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r   <= RX_HUNT;
      el_r      <= 13'h0000;
      est_r     <= 13'h0000;
      zcnt_r    <= 4'h0;
      rbit_r    <= 3'd0;
      rx_sh_r   <= 8'h00;
      rx_hold_r <= 8'h00;
      rx_rdy_r  <= 1'b0;
      rd_prev_r <= 1'b0;
    end else if (clk_en) begin
      rd_prev_r <= rd_s;
      if (el_r != 13'h1FFF) begin
        el_r <= el_r + 13'h0001;
      end
      if (byte_done && !rx_rdy_r) begin
        rx_hold_r <= {rx_sh_r[6:0], rise};
        rx_rdy_r  <= 1'b1;
      end else if (rd_rxd) begin
        rx_rdy_r <= 1'b0;
      end
      case (rx_st_r)
        RX_HUNT: begin
          zcnt_r <= 4'h0;
          if (rx_en && fall) begin
            rx_st_r <= RX_PRE;
            el_r    <= 13'h0000;
          end
        end
        RX_PRE: begin
          if (!rx_en || (zcnt_r != 4'h0 && el_r > {est_r[11:0], 1'b0})) begin
            rx_st_r <= RX_HUNT;
          end else if (fall) begin
            est_r  <= el_r;
            el_r   <= 13'h0000;
            zcnt_r <= (zcnt_r == 4'hF) ? zcnt_r : zcnt_r + 4'h1;
          end else if (rise && win && zcnt_r >= `TBC_PRE_MIN) begin
            rx_st_r <= RX_DATA;
            el_r    <= 13'h0000;
            rbit_r  <= 3'd0;
          end
        end
        RX_DATA: begin
          if (!rx_en || el_r > {est_r[11:0], 1'b0}) begin
            rx_st_r <= RX_HUNT;
          end else if (rx_take) begin
            est_r   <= el_r;
            el_r    <= 13'h0000;
            rx_sh_r <= {rx_sh_r[6:0], rise};
            rbit_r  <= rbit_r + 3'd1;
          end
        end
        default: rx_st_r <= RX_HUNT;
      endcase
    end
  end

  tbc_crc u_rx_crc (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .clr      (rx_st_r == RX_PRE),
    .shift_en (rx_take & ctrl_r[`TBC_C_RXCHK]),
    .emit     (1'b0),
    .din      (rise),
    .crc      (rx_crc)
  );
endmodule // tbc_codec
`default_nettype wire

// >>> design/tbc_crc.v
// Serial 16-bit check generator and checker, MSB first.
// Assumes polynomial and initial value shared by all instances.
`timescale 1ns/1ns
`default_nettype none
`include "tbc_regs.vh"
module tbc_crc (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // Control
  input  wire        clr,
  input  wire        shift_en,
  input  wire        emit,
  input  wire        din,
  // State
  output reg  [15:0] crc
);
  wire fb;

  assign fb = crc[15] ^ din;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc <= `TBC_CRC_INIT;
    end else if (clk_en) begin
      if (clr) begin
        crc <= `TBC_CRC_INIT;
      end else if (shift_en && emit) begin
        crc <= {crc[14:0], 1'b0};
      end else if (shift_en) begin
        crc <= {crc[14:0], 1'b0} ^ (fb ? `TBC_CRC_POLY : 16'h0000);
      end
    end
  end
endmodule // tbc_crc
`default_nettype wire

// >>> design/tbc_regs.vh
// Register map, field positions, reset values and timing counts of the tape block codec.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef TBC_REGS_VH
`define TBC_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TBC_OFF_CTRL    8'h00
`define TBC_OFF_STAT    8'h04
`define TBC_OFF_TXD     8'h08
`define TBC_OFF_RXD     8'h0C
`define TBC_OFF_GAP     8'h10
`define TBC_OFF_RETRY   8'h14

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TBC_C_WG        0
`define TBC_C_ENC       1
`define TBC_C_ACC       2
`define TBC_C_EMIT      3
`define TBC_C_APPEND    4
`define TBC_C_RUN       5
`define TBC_C_FAST      6
`define TBC_C_FWD       7
`define TBC_C_RXCHK     8
`define TBC_C_BACKUP    9

// ----------------------------------------
// Status fields
// ----------------------------------------
`define TBC_S_TXEMPTY   0
`define TBC_S_RXRDY     1
`define TBC_S_ERR       2
`define TBC_S_MISMATCH  3
`define TBC_S_SYNCED    4
`define TBC_S_DONE      5
`define TBC_S_RETRYEXH  6
`define TBC_S_GAPSEEN   7

// ----------------------------------------
// Reset values and check polynomial
// ----------------------------------------
`define TBC_RST_GAP     16'h0010
`define TBC_RST_RMAX    4'h3
`define TBC_CRC_POLY    16'h8005
`define TBC_CRC_INIT    16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define TBC_CLK_MHZ     50
`define TBC_BIT_NS      20833
`define TBC_HALF_CYC    ((`TBC_BIT_NS * `TBC_CLK_MHZ) / 2000)
`define TBC_BACKUP_MIL  3000
`define TBC_TACH_TMIL   76
`define TBC_BACKUP_PLS  ((`TBC_BACKUP_MIL * 10 + `TBC_TACH_TMIL - 1) / `TBC_TACH_TMIL)
`define TBC_PRE_MIN     4

`endif

// >>> design/tbc_sync.v
// Two-stage synchroniser for inputs from outside the pclk domain.
// Assumes pclk, active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module tbc_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  input  wire         clk_en,
  // Data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else if (clk_en) begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // tbc_sync
`default_nettype wire

// >>> dv/tbc_codec_properties.sv
// Concurrent checks on the tape block codec ports.
// Assumes binding into tbc_codec, one pclk domain, presetn active low.
`timescale 1ns/1ns
`default_nettype none
module tbc_codec_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Head and motion
  input wire logic        write_gate,
  input wire logic        write_data,
  input wire logic        run_tape,
  input wire logic        tape_fast,
  input wire logic        tape_fwd
);
  logic [11:0] hb_cnt;
  logic        wd_prev;
  wire         ctrl_wr = psel && penable && pready && pwrite && (paddr == 8'h00);

  // Cycles since the last flux change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_cnt  <= 12'h000;
      wd_prev <= 1'b0;
    end else begin
      wd_prev <= write_data;
      if (write_data != wd_prev) hb_cnt <= 12'h001;
      else if (hb_cnt != 12'hFFF) hb_cnt <= hb_cnt + 12'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_slverr_map: assert property (pready |-> (pslverr == ((paddr > 8'h14) || (paddr[1:0] != 2'b00))))
    else $error("pslverr wrong for address");
  a_slverr_zero_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_flux_spacing: assert property ($changed(write_data) |->
    ((hb_cnt >= 12'h207 && hb_cnt <= 12'h209) || hb_cnt >= 12'h40F))
    else $error("flux change off the half-bit grid");
  a_gate_follows: assert property (ctrl_wr && pwdata[0] && !pwdata[4] |-> ##[1:2] write_gate)
    else $error("write gate not raised");
  a_motion_follows: assert property (ctrl_wr && !pwdata[9] |=> ##1
    run_tape == $past(pwdata[5], 2) && tape_fast == $past(pwdata[6], 2) && tape_fwd == $past(pwdata[7], 2))
    else $error("motion outputs do not follow control");
  a_backup_reverse: assert property (ctrl_wr && pwdata[9] |-> ##[1:2] (run_tape && !tape_fwd && !tape_fast))
    else $error("backup not reversing slow");
  a_done_stopped: assert property (pready && !pwrite && paddr == 8'h04 && prdata[5] |-> !run_tape)
    else $error("tape still running after done");
endmodule // tbc_codec_properties

bind tbc_codec tbc_codec_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_gate(write_gate),
  .write_data(write_data), .run_tape(run_tape), .tape_fast(tape_fast), .tape_fwd(tape_fwd)
);
`default_nettype wire

// >>> dv/tbc_tape_model.sv
// Tape head and tachometer model: write flux reaches the read gap after a fixed skew.
// Assumes pclk from the bench; tachometer runs only while the tape runs.
`timescale 1ns/1ns
`default_nettype none
module tbc_tape_model #(
  parameter int SKEW = 300
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Head
  input  wire logic write_gate,
  input  wire logic write_data,
  output logic      read_data,
  // Motion
  input  wire logic run_tape,
  output logic      tach_pulse
);
  logic [SKEW-1:0] track_r;

  // Written flux travels to the read gap; ungated tape keeps its level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) track_r <= '0;
    else track_r <= {track_r[SKEW-2:0], write_gate ? write_data : track_r[0]};
  end
  assign read_data = track_r[SKEW-1];

  // Tachometer, 160 ns period, still while stopped
  initial begin
    tach_pulse = 1'b0;
    #7;
    forever begin
      #80;
      tach_pulse = run_tape ? ~tach_pulse : 1'b0;
    end
  end
endmodule // tbc_tape_model
`default_nettype wire

// >>> dv/testbench.sv
// Bench: registers, one short block written and read back, under-run, backup.
// Assumes the tape model loops write flux to the read head.
`timescale 1ns/1ns
`default_nettype none
`include "tbc_regs.vh"
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv, st;
  logic        pready, pslverr, bus_err, write_gate, write_data, read_data, tach_pulse;
  logic        run_tape, tape_fast, tape_fwd;
  int          errors = 0;
  int          n_checks = 0;
  int          n_rx = 0;
  logic [7:0]  exp_q[$];

  always #10 pclk = ~pclk;

  tbc_codec dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_gate(write_gate), .write_data(write_data), .read_data(read_data), .tach_pulse(tach_pulse),
    .run_tape(run_tape), .tape_fast(tape_fast), .tape_fwd(tape_fwd));
  tbc_tape_model tape (.pclk(pclk), .presetn(presetn), .write_gate(write_gate), .write_data(write_data),
    .read_data(read_data), .run_tape(run_tape), .tach_pulse(tach_pulse));

  task automatic stop_test;
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int   n = 0;
    logic rdy;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      rdy     = pready;
      r       = prdata;
      bus_err = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 16);
    psel    <= 1'b0;
    penable <= 1'b0;
    check(32'(rdy), 32'h0000_0001, "apb ready");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, rdv);
  endtask

  // Polls status and drains received bytes until st[bitn] is set and nrx bytes came in
  task automatic service(input int bitn, input int nrx);
    int k = 0;
    do begin
      rd(`TBC_OFF_STAT);
      st = rdv;
      if (st[`TBC_S_RXRDY] === 1'b1) begin
        rd(`TBC_OFF_RXD);
        check(rdv, {24'h00_0000, exp_q.pop_front()}, "rx byte");
        n_rx++;
      end
      k++;
    end while (!((bitn < 0 || st[bitn] === 1'b1) && n_rx >= nrx) && k < 20000);
    check(32'(k < 20000), 32'h0000_0001, "status wait");
  endtask

  function automatic logic [15:0] crc8(input logic [7:0] b, input logic [15:0] c);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `TBC_CRC_POLY : 16'h0000);
    return c;
  endfunction

  initial begin
    #2_000_000;
    errors++;
    stop_test;
  end

  initial begin
    logic [7:0]  d0, slot_b[0:8];
    logic [31:0] slot_c[0:8];
    logic [15:0] c;
    logic        prev;
    int          rises;
    void'($urandom(53));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // ----
    // Reset values, unmapped access, read/write register
    // ----
    rd(`TBC_OFF_CTRL);
    check(rdv, 32'h0000_0000, "ctrl reset");
    rd(`TBC_OFF_GAP);
    check(rdv, {16'h0000, `TBC_RST_GAP}, "gap reset");
    rd(`TBC_OFF_RETRY);
    check(rdv, {28'h000_0000, `TBC_RST_RMAX}, "retry reset");
    rd(8'h18);
    check(32'(bus_err), 32'h0000_0001, "unmapped error");
    st = $urandom;
    wr(`TBC_OFF_GAP, st);
    rd(`TBC_OFF_GAP);
    check(rdv, {16'h0000, st[15:0]}, "gap rw");
    wr(`TBC_OFF_GAP, 32'h0000_0001);
    // ----
    // One block: gap, preamble, data, check, postamble, gap
    // ----
    d0 = 8'($urandom_range(255, 1));
    c = crc8(d0, `TBC_CRC_INIT);
    exp_q = {d0, c[15:8], c[7:0], 8'h80, 8'h00};
    slot_b = '{8'h00, 8'h00, 8'h01, d0, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    slot_c = '{32'h0000_00A1, 32'h0000_00A3, 32'h0000_00A3, 32'h0000_01A7, 32'h0000_01AF,
               32'h0000_01AF, 32'h0000_01A3, 32'h0000_00A3, 32'h0000_00A1};
    for (int i = 0; i < 9; i++) begin
      if (i == 0) wr(`TBC_OFF_TXD, {24'h00_0000, slot_b[0]});
      else service(`TBC_S_TXEMPTY, n_rx);
      wr(`TBC_OFF_CTRL, slot_c[i]);
      if (i > 0) wr(`TBC_OFF_TXD, {24'h00_0000, slot_b[i]});
      if (i == 6) begin
        service(-1, 3);
        rd(`TBC_OFF_STAT);
        check(32'(rdv[`TBC_S_MISMATCH]), 32'h0000_0000, "check mismatch");
        wr(`TBC_OFF_CTRL, 32'h0000_00A3);
      end
    end
    st = 32'h0000_0000;
    for (int i = 0; i < 30000 && st[`TBC_S_DONE] !== 1'b1; i++) begin
      service(-1, 0);
      if (st[`TBC_S_TXEMPTY] === 1'b1 && st[`TBC_S_DONE] !== 1'b1) wr(`TBC_OFF_TXD, 32'h0000_0000);
    end
    wr(`TBC_OFF_CTRL, 32'h0000_0000);
    check(32'(st[`TBC_S_DONE]), 32'h0000_0001, "block done");
    check(32'(st[`TBC_S_ERR]), 32'h0000_0000, "no error");
    check(n_rx, 32'h0000_0005, "bytes read back");
    check(32'(run_tape), 32'h0000_0000, "tape stopped");
    rd(`TBC_OFF_RETRY);
    check(rdv & 32'h0000_0F00, 32'h0000_0000, "no retry");
    wr(`TBC_OFF_STAT, 32'h0000_0020);
    rd(`TBC_OFF_STAT);
    check(32'(rdv[`TBC_S_DONE]), 32'h0000_0000, "done cleared");
    // ----
    // Gate with nothing loaded: under-run
    // ----
    wr(`TBC_OFF_CTRL, 32'h0000_0001);
    service(`TBC_S_ERR, 0);
    check(32'(st[`TBC_S_ERR]), 32'h0000_0001, "under-run");
    wr(`TBC_OFF_CTRL, 32'h0000_0000);
    wr(`TBC_OFF_STAT, 32'h0000_0004);
    rd(`TBC_OFF_STAT);
    check(32'(rdv[`TBC_S_ERR]), 32'h0000_0000, "error cleared");
    // ----
    // Backup distance in tachometer pulses
    // ----
    wr(`TBC_OFF_CTRL, 32'h0000_02A0);
    rises = 0;
    prev = tach_pulse;
    for (int i = 0; i < 6000 && tape_fwd !== 1'b1; i++) begin
      @(posedge pclk);
      if (tach_pulse && !prev && !tape_fwd) rises++;
      prev = tach_pulse;
    end
    check(32'(rises == `TBC_BACKUP_PLS || rises == `TBC_BACKUP_PLS + 1), 32'h0000_0001, "backup pulses");
    check(32'(run_tape), 32'h0000_0001, "runs forward");
    wr(`TBC_OFF_CTRL, 32'h0000_0000);
    stop_test;
  end
endmodule // testbench
`default_nettype wire
